//--- hscb_map.vh
// Register map and field layout of the hub string, charge and boost bank.
// Assumes a byte-wide configuration port with 8-bit printed offsets.
`ifndef HSCB_MAP_VH
`define HSCB_MAP_VH

// String regions, 62 bytes each
`define HSCB_PRD_BASE 8'h54
`define HSCB_PRD_LAST 8'h91
`define HSCB_SER_BASE 8'h92
`define HSCB_SER_LAST 8'hcf
`define HSCB_TEXT_BYTES 62
`define HSCB_MAX_CHARS 8'h1f

// Single registers
`define HSCB_PRD_LEN_ADDR 8'h14
`define HSCB_SER_LEN_ADDR 8'h15
`define HSCB_CHG_ADDR 8'hd0
`define HSCB_UPB_ADDR 8'hf6
`define HSCB_DNB_ADDR 8'hf8

// Writable bits; all others reserved
`define HSCB_CHG_MASK 8'h1e
`define HSCB_UPB_MASK 8'h03
`define HSCB_DNB_MASK 8'hff
`define HSCB_LEN_MASK 8'hff

// Reset values
`define HSCB_CHG_RESET 8'h00
`define HSCB_UPB_RESET 8'h00
`define HSCB_DNB_RESET 8'h00
`define HSCB_LEN_RESET 8'h00

// Field positions
`define HSCB_CHG_P1_BIT 1
`define HSCB_CHG_P4_BIT 4
`define HSCB_UPB_LSB 0
`define HSCB_DNB_P1_LSB 0
`define HSCB_DNB_P2_LSB 2
`define HSCB_DNB_P3_LSB 4
`define HSCB_DNB_P4_LSB 6

// Drive boost codes
`define HSCB_BOOST_NONE 2'h0
`define HSCB_BOOST_LOW 2'h1
`define HSCB_BOOST_MED 2'h2
`define HSCB_BOOST_HIGH 2'h3

`endif

//--- hscb_text_ram.v
// Byte store for one UTF-16LE descriptor string region.
// Assumes writes and reads come from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none

module hscb_text_ram #(
    parameter DEPTH = 62,
    parameter AW = 6,
    parameter CW = 5
) (
    input wire ref_clk,            // Bank clock
    input wire wr_en,              // Byte write strobe
    input wire [AW-1:0] wr_addr,   // Byte index in region
    input wire [7:0] wr_data,      // Byte to store
    input wire [AW-1:0] rd_addr,   // Bus read byte index
    output wire [7:0] rd_data,     // Bus read byte
    input wire [CW-1:0] chr_index, // Character index
    output wire [15:0] chr_data    // Character, low byte from even addr
);

    reg [7:0] mem_q [0:DEPTH-1];
    wire [CW:0] lo_idx; // Byte index, one bit wider than the character
    wire [CW:0] hi_idx;

    ////////////////////////////////////////////////////////////////////////
    // Storage has no reset; length registers say what is valid
    always @(posedge ref_clk)
    begin
        if (wr_en && (wr_addr < DEPTH))
        begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Out of range indices read zero
    assign rd_data = (rd_addr < DEPTH) ? mem_q[rd_addr] : 8'h00;

    // Low byte first at the lower address (see [RULE_03])
    assign lo_idx = {chr_index, 1'b0};
    assign hi_idx = {chr_index, 1'b1};
    assign chr_data = (hi_idx < DEPTH) ?
        {mem_q[hi_idx], mem_q[lo_idx]} : 16'h0000;

endmodule // hscb_text_ram

`default_nettype wire

//--- hscb_config.v
// Hub configuration bank: descriptor strings, charge enables, drive boost.
// Assumes a byte register port driven by the EEPROM or SMBus loader logic
// on ref_clk, and a hub core reading strings and settings on ref_clk.
//
// Operation
// [RULE_01] Product string region holds up to 31 characters in 62 bytes.
// [RULE_02] Serial string region 92h-CFh holds up to 31 UTF-16LE characters.
// [RULE_03] Each character stored low byte at lower address, high byte next.
// [RULE_04] Charge enable bits 1 to 4 enable ports 1 to 4; others reserved.
// [RULE_05] Upstream boost selector in bits 1:0; bits 7:2 reserved.
// [RULE_06] Boost code 00 none, 01 low, 10 medium, 11 high.
// [RULE_07] Downstream boost: port4 7:6, port3 5:4, port2 3:2, port1 1:0.
// [RULE_08] Loader should program boost 00 unless signalling needs help.
// [RULE_09] Length registers give product and serial character counts, max 31.
// [RULE_10] Reserved bits read zero; fields held stable after configuration.
`timescale 1ns/1ps
`default_nettype none
`include "hscb_map.vh"

module hscb_config (
    input wire ref_clk,                   // 100 MHz clock
    input wire sys_rst,                   // Async reset, active high
    input wire cfg_wr_en,                 // Register write strobe
    input wire cfg_rd_en,                 // Register read strobe
    input wire [7:0] cfg_addr,            // Register byte address
    input wire [7:0] cfg_wdata,           // Write data
    output reg [7:0] cfg_rdata,           // Read data, one cycle later
    output reg cfg_rvalid,                // Read data valid pulse
    input wire cfg_done,                  // Loader finished configuring
    output reg config_ready,              // Settings applied and locked
    input wire core_text_sel,             // 0 product, 1 serial
    input wire core_char_rd,              // Character read strobe
    input wire [4:0] core_char_index,     // Character number
    output reg [15:0] core_char_data,     // Character read result
    output reg core_char_valid,           // Character valid pulse
    output reg [3:0] charge_port_enable,  // Bit 0 is port 1
    output reg [1:0] upstream_drive_level,// Upstream boost code
    output reg [1:0] port1_drive_level,   // Port 1 boost code
    output reg [1:0] port2_drive_level,   // Port 2 boost code
    output reg [1:0] port3_drive_level,   // Port 3 boost code
    output reg [1:0] port4_drive_level,   // Port 4 boost code
    output reg [4:0] product_text_length, // Product characters, max 31
    output reg [4:0] serial_text_length   // Serial characters, max 31
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Address inside an inclusive region
    function in_region;
        input [7:0] addr;
        input [7:0] first;
        input [7:0] last;
        begin
            in_region = (addr >= first) && (addr <= last);
        end
    endfunction

    // Byte index from region base
    function [5:0] region_offset;
        input [7:0] addr;
        input [7:0] base;
        reg [7:0] diff;
        begin
            diff = addr - base;
            region_offset = diff[5:0];
        end
    endfunction

    // Length clamped to the character limit
    function [4:0] clamp_len;
        input [7:0] len;
        reg [7:0] lim;
        begin
            lim = `HSCB_MAX_CHARS;
            if (len > lim)
            begin
                clamp_len = lim[4:0];
            end
            else
            begin
                clamp_len = len[4:0];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decode

    reg [7:0] chg_q;
    reg [7:0] upb_q;
    reg [7:0] dnb_q;
    reg [7:0] prd_len_q;
    reg [7:0] ser_len_q;
    wire wr_ok;
    wire prd_hit;
    wire ser_hit;
    wire [5:0] prd_off;
    wire [5:0] ser_off;
    wire [7:0] prd_byte;
    wire [7:0] ser_byte;
    wire [15:0] prd_chr;
    wire [15:0] ser_chr;
    wire apply;
    reg [7:0] rd_d;

    // Writes after lock are dropped so the core sees stable settings
    assign wr_ok = cfg_wr_en && !config_ready; // see [RULE_10]
    assign prd_hit = in_region(cfg_addr, `HSCB_PRD_BASE,
        `HSCB_PRD_LAST); // see [RULE_01]
    assign ser_hit = in_region(cfg_addr, `HSCB_SER_BASE,
        `HSCB_SER_LAST); // see [RULE_02]
    assign prd_off = region_offset(cfg_addr, `HSCB_PRD_BASE);
    assign ser_off = region_offset(cfg_addr, `HSCB_SER_BASE);
    assign apply = cfg_done && !config_ready;

    ////////////////////////////////////////////////////////////////////////
    // String stores, 62 bytes each

    hscb_text_ram #(
        .DEPTH(`HSCB_TEXT_BYTES),
        .AW(6),
        .CW(5)
    ) u_prd_ram (
        .ref_clk(ref_clk),
        .wr_en(wr_ok && prd_hit), // see [RULE_01]
        .wr_addr(prd_off),
        .wr_data(cfg_wdata),
        .rd_addr(prd_off),
        .rd_data(prd_byte),
        .chr_index(core_char_index),
        .chr_data(prd_chr)
    );

    hscb_text_ram #(
        .DEPTH(`HSCB_TEXT_BYTES),
        .AW(6),
        .CW(5)
    ) u_ser_ram (
        .ref_clk(ref_clk),
        .wr_en(wr_ok && ser_hit), // see [RULE_02]
        .wr_addr(ser_off),
        .wr_data(cfg_wdata),
        .rd_addr(ser_off),
        .rd_data(ser_byte),
        .chr_index(core_char_index),
        .chr_data(ser_chr)
    );

    ////////////////////////////////////////////////////////////////////////
    // Control registers; reserved bits never stored
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            chg_q <= `HSCB_CHG_RESET;
            upb_q <= `HSCB_UPB_RESET;
            dnb_q <= `HSCB_DNB_RESET;
            prd_len_q <= `HSCB_LEN_RESET;
            ser_len_q <= `HSCB_LEN_RESET;
        end
        else if (wr_ok)
        begin
            case (cfg_addr)
                `HSCB_CHG_ADDR:
                    chg_q <= cfg_wdata & `HSCB_CHG_MASK; // see [RULE_04]
                `HSCB_UPB_ADDR:
                    upb_q <= cfg_wdata & `HSCB_UPB_MASK; // see [RULE_05]
                `HSCB_DNB_ADDR:
                    dnb_q <= cfg_wdata & `HSCB_DNB_MASK; // see [RULE_07]
                `HSCB_PRD_LEN_ADDR:
                    prd_len_q <= cfg_wdata & `HSCB_LEN_MASK; // see [RULE_09]
                `HSCB_SER_LEN_ADDR:
                    ser_len_q <= cfg_wdata & `HSCB_LEN_MASK; // see [RULE_09]
                default:
                    chg_q <= chg_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped and reserved bits read zero
    always @*
    begin
        rd_d = 8'h00;
        if (prd_hit)
        begin
            rd_d = prd_byte;
        end
        else if (ser_hit)
        begin
            rd_d = ser_byte;
        end
        else
        begin
            case (cfg_addr)
                `HSCB_CHG_ADDR: rd_d = chg_q; // see [RULE_10]
                `HSCB_UPB_ADDR: rd_d = upb_q; // see [RULE_10]
                `HSCB_DNB_ADDR: rd_d = dnb_q;
                `HSCB_PRD_LEN_ADDR: rd_d = prd_len_q;
                `HSCB_SER_LEN_ADDR: rd_d = ser_len_q;
                default: rd_d = 8'h00;
            endcase
        end
    end

    // Registered read answer
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_rdata <= 8'h00;
            cfg_rvalid <= 1'b0;
        end
        else
        begin
            cfg_rvalid <= cfg_rd_en;
            if (cfg_rd_en)
            begin
                cfg_rdata <= rd_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Apply settings once when the loader finishes; held until reset.
    // Boost codes pass through as written; the loader should keep them at
    // the no-boost code unless signalling is degraded.
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            config_ready <= 1'b0;
            charge_port_enable <= 4'h0;
            upstream_drive_level <= `HSCB_BOOST_NONE;
            port1_drive_level <= `HSCB_BOOST_NONE;
            port2_drive_level <= `HSCB_BOOST_NONE;
            port3_drive_level <= `HSCB_BOOST_NONE;
            port4_drive_level <= `HSCB_BOOST_NONE;
            product_text_length <= 5'h00;
            serial_text_length <= 5'h00;
        end
        else if (apply)
        begin
            config_ready <= 1'b1; // see [RULE_10]
            charge_port_enable <= chg_q[`HSCB_CHG_P4_BIT:`HSCB_CHG_P1_BIT];
            // see [RULE_04]
            upstream_drive_level <= upb_q[`HSCB_UPB_LSB+:2]; // see [RULE_05]
            // Two-bit codes kept verbatim (see [RULE_06])
            port1_drive_level <= dnb_q[`HSCB_DNB_P1_LSB+:2]; // see [RULE_07]
            port2_drive_level <= dnb_q[`HSCB_DNB_P2_LSB+:2]; // see [RULE_07]
            port3_drive_level <= dnb_q[`HSCB_DNB_P3_LSB+:2]; // see [RULE_07]
            port4_drive_level <= dnb_q[`HSCB_DNB_P4_LSB+:2]; // see [RULE_07]
            product_text_length <= clamp_len(prd_len_q); // see [RULE_09]
            serial_text_length <= clamp_len(ser_len_q); // see [RULE_09]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core character reads, one cycle latency; index 31 is beyond limit
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            core_char_data <= 16'h0000;
            core_char_valid <= 1'b0;
        end
        else
        begin
            core_char_valid <= core_char_rd;
            if (core_char_rd)
            begin
                if (core_char_index >= `HSCB_MAX_CHARS)
                begin
                    core_char_data <= 16'h0000; // see [RULE_01]
                end
                else if (core_text_sel)
                begin
                    core_char_data <= ser_chr; // see [RULE_03]
                end
                else
                begin
                    core_char_data <= prd_chr; // see [RULE_03]
                end
            end
        end
    end

endmodule // hscb_config

`default_nettype wire

//--- hscb_config_props.sv
// Checker: read timing, reserved bits, apply and lock.
// Assumes a bind onto hscb_config, one ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module hscb_config_props (
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic cfg_rd_en, // Read strobe
    input wire logic [7:0] cfg_addr, // Address
    input wire logic [7:0] cfg_rdata, // Read data
    input wire logic cfg_rvalid, // Read valid
    input wire logic cfg_done, // Loader done
    input wire logic config_ready, // Applied
    input wire logic core_char_rd, // Char strobe
    input wire logic [4:0] core_char_index, // Char number
    input wire logic [15:0] core_char_data, // Char data
    input wire logic core_char_valid, // Char valid
    input wire logic [3:0] charge_port_enable, // Enables
    input wire logic [1:0] upstream_drive_level // Up boost
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Decoded places; anything else must read as zero
    wire hit = cfg_addr inside {8'h14, 8'h15, 8'hf6, 8'hf8, [8'h54:8'hd0]};
    ////////////////////////////////////////
    a_rd_answer: assert property (
        cfg_rd_en |=> cfg_rvalid) else $error("read not answered");
    a_hole_zero: assert property (
        cfg_rd_en && !hit |=> cfg_rdata == 8'h00) else $error("hole not 0");
    a_chg_rsvd: assert property (
        cfg_rd_en && cfg_addr == 8'hd0 |=> (cfg_rdata & 8'he1) == 8'h00)
        else $error("charge reserved bits set");
    a_upb_rsvd: assert property (
        cfg_rd_en && cfg_addr == 8'hf6 |=> cfg_rdata[7:2] == 6'h00)
        else $error("boost reserved bits set");
    a_char_answer: assert property (
        core_char_rd |=> core_char_valid) else $error("char not answered");
    a_char_oob: assert property (
        core_char_rd && core_char_index == 5'h1f |=> core_char_data == 16'h0)
        else $error("char 31 not zero");
    a_apply_now: assert property (
        cfg_done && !config_ready |=> config_ready) else $error("no apply");
    a_lock_hold: assert property (
        config_ready |=> config_ready
        && $stable({charge_port_enable, upstream_drive_level}))
        else $error("locked setting moved");
    // Main scenarios reached
    c_apply: cover property (cfg_done && !config_ready);
    c_oob: cover property (core_char_rd && core_char_index == 5'h1f);
    c_hole: cover property (cfg_rd_en && !hit);
endmodule // hscb_config_props
bind hscb_config hscb_config_props u_props (.ref_clk, .sys_rst, .cfg_rd_en,
    .cfg_addr, .cfg_rdata, .cfg_rvalid, .cfg_done, .config_ready,
    .core_char_rd, .core_char_index, .core_char_data, .core_char_valid,
    .charge_port_enable, .upstream_drive_level);
`default_nettype wire

//--- hscb_loader_model.sv
// Loader model: the EEPROM or SMBus side that fills the bank.
// Assumes the bench calls its tasks; drives land 1 ns after ref_clk.
`timescale 1ns/1ps
`default_nettype none
module hscb_loader_model (
    input wire logic ref_clk, // Bank clock
    output logic cfg_wr_en, // Write strobe
    output logic cfg_rd_en, // Read strobe
    output logic [7:0] cfg_addr, // Byte address
    output logic [7:0] cfg_wdata, // Write data
    output logic cfg_done // Loading finished
);
    // Quiet bus from time zero
    initial {cfg_wr_en, cfg_rd_en, cfg_done, cfg_addr, cfg_wdata} = 19'h0;
    ////////////////////////////////////////
    // Held through the sampling edge, then scrambled so stale
    // address or data never looks valid
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge ref_clk);
        #1;
        {cfg_wr_en, cfg_rd_en, cfg_addr, cfg_wdata} = {w, !w, a, d};
        @(posedge ref_clk);
        #1;
        {cfg_wr_en, cfg_rd_en, cfg_addr, cfg_wdata} = {2'b00, ~a, ~d};
    endtask
    // One character, low byte at the even address
    task automatic put_char(input logic [7:0] base, input logic [4:0] i,
        input logic [15:0] c);
        acc(1'b1, base + {2'b00, i, 1'b0}, c[7:0]);
        acc(1'b1, base + {2'b00, i, 1'b1}, c[15:8]);
    endtask
    // Compliant load leaves every selector at no boost
    task automatic safe_boost();
        acc(1'b1, 8'hf6, 8'h00);
        acc(1'b1, 8'hf8, 8'h00);
    endtask
    // Finished flag, a level
    task automatic set_done(input logic v);
        @(posedge ref_clk);
        #1;
        cfg_done = v;
    endtask
endmodule // hscb_loader_model
`default_nettype wire

//--- hscb_config_tb_top.sv
// Bench: loads strings and settings, reads back, applies, locks.
// Assumes the bank, its checker and the loader model are compiled.
`timescale 1ns/1ps
`default_nettype none
module hscb_config_tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst, core_text_sel, core_char_rd;
    logic [4:0] core_char_index;
    wire logic cfg_wr_en, cfg_rd_en, cfg_done, cfg_rvalid, config_ready;
    wire logic core_char_valid;
    wire logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
    wire logic [15:0] core_char_data;
    wire logic [3:0] charge_port_enable;
    wire logic [1:0] upstream_drive_level, port1_drive_level;
    wire logic [1:0] port2_drive_level, port3_drive_level, port4_drive_level;
    wire logic [4:0] product_text_length, serial_text_length;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [15:0] qr[$], qc[$];
    logic [7:0] img [0:127]; // String bytes from 54h up
    logic [7:0] probe [8] = '{8'hd0, 8'hf6, 8'hf8, 8'h14, 8'h15, 8'h00,
        8'hf7, 8'hd1};
    hscb_config u_dut (.ref_clk, .sys_rst, .cfg_wr_en, .cfg_rd_en, .cfg_addr,
        .cfg_wdata, .cfg_rdata, .cfg_rvalid, .cfg_done, .config_ready,
        .core_text_sel, .core_char_rd, .core_char_index, .core_char_data,
        .core_char_valid, .charge_port_enable, .upstream_drive_level,
        .port1_drive_level, .port2_drive_level, .port3_drive_level,
        .port4_drive_level, .product_text_length, .serial_text_length);
    hscb_loader_model u_ldr (.ref_clk, .cfg_wr_en, .cfg_rd_en, .cfg_addr,
        .cfg_wdata, .cfg_done);
    // 100 MHz
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, exp);
        qr.push_back({8'h00, exp});
        u_ldr.acc(1'b0, a, 8'h00);
    endtask
    task automatic chr(input logic s, input logic [4:0] i);
        @(posedge ref_clk);
        #1;
        {core_text_sel, core_char_index, core_char_rd} = {s, i, 1'b1};
        qc.push_back(i < 31 ? {img[62 * s + 2 * i + 1], img[62 * s + 2 * i]}
            : 16'h0000);
        @(posedge ref_clk);
        #1;
        {core_text_sel, core_char_index, core_char_rd} = {!s, ~i, 1'b0};
    endtask
    // Answers come one cycle late, so three edges drain them
    task automatic drain();
        repeat (3) @(posedge ref_clk);
        chk(16'(qr.size() + qc.size()), 16'h0000);
    endtask
    // Answers matched in issue order, away from the launching edge
    always @(negedge ref_clk)
    begin
        if (cfg_rvalid === 1'b1)
            chk({8'h00, cfg_rdata},
                qr.size() ? qr.pop_front() : 'x);
        if (core_char_valid === 1'b1)
            chk(core_char_data,
                qc.size() ? qc.pop_front() : 'x);
    end
    // Hang guard
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end
    initial
    begin
        logic [15:0] c;
        logic [7:0] b, dn;
        {sys_rst, core_text_sel, core_char_rd, core_char_index} = 8'h80;
        b = 8'($urandom(32'hd914));
        repeat (4) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        foreach (probe[k])
            rd(probe[k], 8'h00);
        // Both strings, then every character and the one past the end
        for (int i = 0; i < 62; i++)
        begin
            c = 16'($urandom);
            {img[2 * i + 1], img[2 * i]} = c;
            u_ldr.put_char(i < 31 ? 8'h54 : 8'h92, 5'(i % 31), c);
        end
        for (int i = 0; i < 64; i++)
            chr(1'(i / 32), 5'(i % 32));
        rd(8'h91, img[61]);
        rd(8'hcf, img[123]);
        u_ldr.acc(1'b1, 8'hd0, 8'hff);
        rd(8'hd0, 8'h1e);
        for (int k = 0; k < 4; k++)
        begin
            b = 8'($urandom);
            u_ldr.acc(1'b1, 8'hf6, {b[7:2], 2'(k)});
            rd(8'hf6, {6'h00, 2'(k)});
        end
        dn = 8'($urandom);
        u_ldr.acc(1'b1, 8'hf8, dn);
        u_ldr.acc(1'b1, 8'h14, 8'h1f);
        u_ldr.acc(1'b1, 8'h15, 8'h28);
        rd(8'hf8, dn);
        rd(8'h15, 8'h28);
        // Apply; then late writes are dropped
        u_ldr.set_done(1'b1);
        @(posedge ref_clk);
        #1;
        chk({11'h0, config_ready, charge_port_enable},
            16'h001f);
        chk({14'h0, upstream_drive_level}, 16'h0003);
        chk({port4_drive_level, port3_drive_level,
            port2_drive_level, port1_drive_level, 8'h00}, {dn, 8'h00});
        chk({product_text_length, serial_text_length, 6'h00},
            16'hffc0);
        u_ldr.acc(1'b1, 8'hd0, 8'h00);
        rd(8'hd0, 8'h1e);
        drain();
        // Mid-run reset, then a compliant reload with port 2 only
        u_ldr.set_done(1'b0);
        sys_rst = 1'b1;
        @(posedge ref_clk);
        #1;
        chk({config_ready, charge_port_enable, 11'h0},
            16'h0000);
        sys_rst = 1'b0;
        u_ldr.acc(1'b1, 8'hd0, 8'h04);
        u_ldr.safe_boost();
        u_ldr.set_done(1'b1);
        @(posedge ref_clk);
        #1;
        chk({11'h0, config_ready, charge_port_enable},
            16'h0012);
        chk({port4_drive_level, port3_drive_level,
            port2_drive_level, port1_drive_level, upstream_drive_level,
            6'h01}, 16'h0001);
        drain();
        print_verdict();
    end
endmodule // hscb_config_tb_top
`default_nettype wire
